// ### pkg/uie_params.svh
// Offsets, field positions, reset values and timing counts of the USB interrupt enable/error block.
// Assumes inclusion by the package and the design module; APB with 32-bit data.
// Notes on behaviour
// - Eight RW event enables, bits 7..0, gate the matching event flags.
// - Enable bit 0 means bus reset in device mode, detach in host mode.
// - Error conditions reach the interrupt only while event enable bit 1 is set.
// - Error flags set by hardware, cleared by writing one; zero after reset.
// - Bit 7 flags a bit stuffing violation; the packet is rejected.
// - Bit 6 flags an invalid descriptor table base or buffer address.
// - Bit 5 flags a DMA overflow, underflow or truncated receive.
// - Bit 4 flags more than sixteen idle bit times after an end of packet.
// - Bit 3 flags a data field that is not a whole number of bytes.
// - Bit 2 flags a data packet CRC16 failure; the packet is rejected.
// - In device mode bit 1 flags a token rejected for CRC5 failure.
// - In host mode bit 1 flags an end-of-frame error at frame countdown zero.
// - Error enable register, eight RW bits aligned with the flags, reset zero.
// - Bits 31..8 read zero and ignore writes.
// - The summary error event flag sets only for enabled error conditions.
// - General event flags are sticky, hardware set, cleared by writing one.
`ifndef UIE_PARAMS_SVH
`define UIE_PARAMS_SVH

`define UIE_OFF_EVENT_FLAGS  12'h000
`define UIE_OFF_EVENT_ENABLE 12'h010
`define UIE_OFF_ERROR_FLAGS  12'h020
`define UIE_OFF_ERROR_ENABLE 12'h030
`define UIE_OFF_MODE         12'h040

`define UIE_REG_W            8
`define UIE_BIT_ERROR_EVENT  1
`define UIE_BIT_TURNAROUND   4
`define UIE_BIT_SHARED_ERR   1
`define UIE_RESET_VAL        8'h00
`define UIE_TURNAROUND_BITS  16

`endif

// ### pkg/uie_pkg.sv
// Types shared by the USB interrupt enable/error block.
// Assumes the constants header is on the include path.
package uie_pkg;
  `include "uie_params.svh"

  typedef logic [`UIE_REG_W-1:0] uie_byte_t;

  typedef struct packed {
    uie_byte_t event_flags;
    uie_byte_t event_enable;
    uie_byte_t error_flags;
    uie_byte_t error_enable;
    logic      host_mode;
    logic      prdata_valid;
    logic [31:0] prdata;
  } uie_state_t;
endpackage

// ### design/uie_irq_ctrl.sv
// USB interrupt enable and error reporting logic with an APB register slave.
// Assumes the protocol engine gives one-cycle event and error pulses on clk.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "uie_params.svh"

module uie_irq_ctrl
  import uie_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  event_pulse,
  input  wire logic [7:0]  error_pulse,
  output logic             host_mode,
  output logic             packet_reject,
  output logic             module_irq
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] uie_zext(input uie_byte_t v);
    uie_zext = {24'h00_0000, v};
  endfunction

  uie_state_t state_reg;
  uie_state_t state_next;
  logic       wr_acc;
  logic       rd_acc;
  logic       addr_hit;
  uie_byte_t  wbyte;
  uie_byte_t  err_set;
  uie_byte_t  ev_set;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign wbyte   = pstrb[0] ? pwdata[7:0] : `UIE_RESET_VAL;
  assign addr_hit = (paddr == `UIE_OFF_EVENT_FLAGS) || (paddr == `UIE_OFF_EVENT_ENABLE)
                 || (paddr == `UIE_OFF_ERROR_FLAGS) || (paddr == `UIE_OFF_ERROR_ENABLE)
                 || (paddr == `UIE_OFF_MODE);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    // Error causes ..arrive on their positions; bit 1 is CRC5 or EOF by mode
    err_set = error_pulse;
    ev_set = event_pulse;
    // Summary error event only from enabled errors
    ev_set[`UIE_BIT_ERROR_EVENT] = |(err_set & state_reg.error_enable);
    state_next.prdata_valid = 1'b0;
    if (wr_acc)
    begin
      unique case (paddr)
        `UIE_OFF_EVENT_FLAGS:  state_next.event_flags  = state_reg.event_flags & ~wbyte;
        `UIE_OFF_EVENT_ENABLE: state_next.event_enable = wbyte;
        `UIE_OFF_ERROR_FLAGS:  state_next.error_flags  = state_reg.error_flags & ~wbyte;
        `UIE_OFF_ERROR_ENABLE: state_next.error_enable = wbyte;
        `UIE_OFF_MODE:         state_next.host_mode    = wbyte[0];
        default:               state_next.host_mode    = state_reg.host_mode;
      endcase
    end
    // Set after clear so a same-cycle event wins
    state_next.error_flags = state_next.error_flags | err_set;
    state_next.event_flags = state_next.event_flags | ev_set;
    state_next.prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      unique case (paddr)
        `UIE_OFF_EVENT_FLAGS:  state_next.prdata = uie_zext(state_reg.event_flags);
        `UIE_OFF_EVENT_ENABLE: state_next.prdata = uie_zext(state_reg.event_enable);
        `UIE_OFF_ERROR_FLAGS:  state_next.prdata = uie_zext(state_reg.error_flags);
        `UIE_OFF_ERROR_ENABLE: state_next.prdata = uie_zext(state_reg.error_enable);
        `UIE_OFF_MODE:         state_next.prdata = {31'h0000_0000, state_reg.host_mode};
        default:               state_next.prdata = 32'h0000_0000;
      endcase
      // Read data is registered, so the second access cycle answers
      state_next.prdata_valid = !state_reg.prdata_valid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Reads take one wait state so that read data comes from flip-flops; writes take none
  assign prdata        = state_reg.prdata;
  assign pready        = !rd_acc || state_reg.prdata_valid;
  assign pslverr       = psel && penable && !addr_hit;
  assign host_mode     = state_reg.host_mode;
  assign packet_reject = error_pulse[7] || error_pulse[2];
  // Error bit propagates only through its enable at bit 1
  assign module_irq    = |(state_reg.event_flags & state_reg.event_enable);

  // ************************************************************
  // Assertions
  // ************************************************************
  a_irq_from_flags: assert property (@(posedge clk) disable iff (!rst_n)
    module_irq == |(state_reg.event_flags & state_reg.event_enable))
    else $error("Interrupt does not match flags and enables");

  a_err_gate_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.event_flags == 8'h02 && !state_reg.event_enable[1]) |-> !module_irq)
    else $error("Error event raised interrupt while disabled");

  a_err_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    error_pulse[4] |=> state_reg.error_flags[4])
    else $error("Error flag lost its set");

  a_w1c_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == `UIE_OFF_ERROR_FLAGS && pstrb[0] && pwdata[0] && !error_pulse[0])
      |=> !state_reg.error_flags[0])
    else $error("Write one did not clear error flag");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.error_flags[7] && !(wr_acc && paddr == `UIE_OFF_ERROR_FLAGS)) |=> state_reg.error_flags[7])
    else $error("Error flag dropped without a clear");

  a_summary_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (error_pulse != 8'h00 && (error_pulse & state_reg.error_enable) == 8'h00 && !event_pulse[1]
      && !state_reg.event_flags[1] && !wr_acc) |=> !state_reg.event_flags[1])
    else $error("Summary flag set by a disabled error");

  a_summary_set: assert property (@(posedge clk) disable iff (!rst_n)
    ((error_pulse & state_reg.error_enable) != 8'h00) |=> state_reg.event_flags[1])
    else $error("Summary flag missed an enabled error");

  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_acc |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper bits read non-zero");

  a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == `UIE_OFF_ERROR_ENABLE && pstrb[0]) |=> state_reg.error_enable == $past(pwdata[7:0]))
    else $error("Error enable write not stored");

  a_read_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_acc && !state_reg.prdata_valid) |-> !pready)
    else $error("Read answered before its data was registered");

  a_reject_echo: assert property (@(posedge clk) disable iff (!rst_n)
    packet_reject == (error_pulse[7] || error_pulse[2]))
    else $error("Packet reject does not follow bit stuff or CRC16 error");

  a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.event_flags[7] && !(wr_acc && paddr == `UIE_OFF_EVENT_FLAGS)) |=> state_reg.event_flags[7])
    else $error("Event flag dropped without a clear");

  a_reset_clear: assert property (@(posedge clk)
    !rst_n |=> (state_reg.error_flags == 8'h00 && state_reg.error_enable == 8'h00))
    else $error("Registers not cleared by reset");

  c_read_wait: cover property (@(posedge clk) disable iff (!rst_n) rd_acc && state_reg.prdata_valid);
  c_err_irq:   cover property (@(posedge clk) disable iff (!rst_n) error_pulse[2] ##2 module_irq);
  c_clear_hit: cover property (@(posedge clk) disable iff (!rst_n)
    wr_acc && paddr == `UIE_OFF_ERROR_FLAGS && error_pulse != 8'h00);
  c_host_eof:  cover property (@(posedge clk) disable iff (!rst_n) host_mode && error_pulse[1]);

endmodule // uie_irq_ctrl

// ### bench/uie_engine_model.sv
// Protocol engine model: reports bus events and errors as one-cycle pulses.
// Assumes a caller synchronous to clk; pulses start and end right after rising edges.
`timescale 1ns/1ps
module uie_engine_model (
  input  wire logic       clk,
  output logic      [7:0] event_pulse,
  output logic      [7:0] error_pulse
);
  initial {event_pulse, error_pulse} = 16'h0000;
  // One detected condition per set bit, held for exactly one cycle
  task automatic fire(input logic [7:0] ev, input logic [7:0] er);
    @(posedge clk);
    event_pulse <= ev;
    error_pulse <= er;
    @(posedge clk);
    event_pulse <= 8'h00;
    error_pulse <= 8'h00;
  endtask
endmodule // uie_engine_model

// ### bench/usb_irq_enable_error_logic_test.sv
// Testbench of the USB interrupt enable and error logic over APB.
// Assumes the engine model drives the pulse inputs; APB slave may insert wait states.
`timescale 1ns/1ps
module usb_irq_enable_error_logic_test
  import uie_pkg::*;
();
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, host_mode, packet_reject, module_irq;
  logic [7:0]  event_pulse, error_pulse, ev, en;
  logic [32:0] exp_q[$];
  int          bad_count = 0, cmp_count = 0;
  uie_irq_ctrl dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pulse(event_pulse), .error_pulse(error_pulse), .host_mode(host_mode),
    .packet_reject(packet_reject), .module_irq(module_irq));
  uie_engine_model eng_u (.clk(clk), .event_pulse(event_pulse), .error_pulse(error_pulse));
  always #5 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      close_out();
    end
    {psel, penable} <= 2'b00;
  endtask
  // Notes the expected error response from the map, then reads
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({!(a inside {12'h000, 12'h010, 12'h020, 12'h030, 12'h040}), e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk);
    cmp_val({32'h0000_0000, module_irq}, {32'h0000_0000, e});
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite)
      cmp_val({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_ffff_ffff);
    if (rst_n)
      cmp_val({32'h0000_0000, packet_reject}, {32'h0000_0000, error_pulse[7] | error_pulse[2]});
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(3));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(12'h010 * i, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    rd(12'h010, 32'h0000_00ff);
    apb(1'b1, 12'h030, 32'hffff_ff00);
    rd(12'h030, 32'h0000_0000);
    apb(1'b1, 12'h030, 32'h0000_00ff);
    rd(12'h030, 32'h0000_00ff);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'h010, 32'h0000_0000);
      eng_u.fire(8'h00, 8'h01 << i);
      rd(12'h020, 32'h0000_0001 << i);
      rd(12'h000, 32'h0000_0002);
      irq_is(1'b0);
      apb(1'b1, 12'h010, 32'h0000_0002);
      irq_is(1'b1);
      apb(1'b1, 12'h020, 32'h0000_0000);
      rd(12'h020, 32'h0000_0001 << i);
      apb(1'b1, 12'h020, 32'h0000_0001 << i);
      apb(1'b1, 12'h000, 32'h0000_0002);
      irq_is(1'b0);
    end
    apb(1'b1, 12'h030, 32'h0000_0000);
    eng_u.fire(8'h00, 8'h10);
    rd(12'h000, 32'h0000_0000);
    fork
      apb(1'b1, 12'h020, 32'h0000_0014);
      begin
        @(posedge clk);
        eng_u.fire(8'h00, 8'h04);
      end
    join
    rd(12'h020, 32'h0000_0004);
    apb(1'b1, 12'h040, 32'h0000_0001);
    irq_is(1'b0);
    cmp_val({32'h0000_0000, host_mode}, 33'h0_0000_0001);
    eng_u.fire(8'h00, 8'h02);
    rd(12'h020, 32'h0000_0006);
    for (int i = 0; i < 4; i++)
    begin
      ev = $urandom;
      en = $urandom;
      apb(1'b1, 12'h010, {24'h00_0000, en});
      eng_u.fire(ev, 8'h00);
      rd(12'h000, {24'h00_0000, ev & 8'hfd});
      irq_is(|(ev & en & 8'hfd));
      apb(1'b1, 12'h000, 32'h0000_00ff);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h020, 32'h0000_0000);
    rd(12'h040, 32'h0000_0000);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // usb_irq_enable_error_logic_test
